// file: design/step_select_pkg.sv
// Package for the sample sequence input select block.
// Assumes an APB master with 32-bit data and a sequencer that supplies the step index.
package step_select_pkg;
   localparam int          NUM_STEPS       = 8;
   localparam int          SEL_W           = 2;
   localparam int          STEP_STRIDE     = 4;
   localparam logic [11:0] SEL_REG_OFFSET  = 12'h000;
   localparam logic [31:0] SEL_REG_RESET   = 32'h0000_0000;
   // Writable bits: two-bit fields at 1:0, 5:4, ... 29:28
   localparam logic [31:0] SEL_WRITE_MASK  = 32'h3333_3333;
   localparam int          STEP1_LSB       = 0;
   localparam int          STEP2_LSB       = 4;
   localparam int          STEP3_LSB       = 8;
   localparam int          STEP4_LSB       = 12;
   localparam int          STEP5_LSB       = 16;
   localparam int          STEP6_LSB       = 20;
   localparam int          STEP7_LSB       = 24;
   localparam int          STEP8_LSB       = 28;

   typedef logic [SEL_W-1:0] sel_t;

   typedef struct packed {
      logic       running;
      logic [2:0] step;
   } seq_status_s;

   typedef struct packed {
      logic [11:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } apb_req_s;
endpackage

// file: design/step_field_pick.sv
// Picks the two-bit select field of one step out of the select word.
// Assumes step index 0 means the first step.
`timescale 1ns/100ps
module step_field_pick
   import step_select_pkg::*;
(
   input  wire logic [31:0] word,
   input  wire logic [2:0]  step,
   output sel_t             sel
);
   logic [4:0] lsb;

   always_comb begin
      lsb = {step, 2'b00};
      sel = word[lsb +: SEL_W];
   end
endmodule

// file: design/seq_input_select.sv
// APB register holding the per-step analog input selects and the live select driven to the input mux.
// Assumes a sequencer that reports running and current step index synchronously to pclk.
`timescale 1ns/100ps
// Behaviour
// - The fifth step converts the input named by bits 17:16, which are read/write and reset to zero.
// - The fourth step converts the input named by bits 13:12, which are read/write and reset to zero.
// - The third step converts the input named by bits 9:8, which are read/write and reset to zero.
// - The second step converts the input named by bits 5:4, which are read/write and reset to zero.
// - The first step converts the input named by bits 1:0, which are read/write and reset to zero.
// - The gap bits between the low fields read zero and ignore writes.
module seq_input_select
   import step_select_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        seq_running,
   input  wire logic [2:0]  seq_step,
   output sel_t             analog_input_sel,
   output logic             analog_sel_valid
);
   logic [31:0] sel_word_r, sel_word_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic        pready_r, pready_nxt;
   logic        pslverr_r, pslverr_nxt;
   sel_t        amux_r, amux_nxt;
   logic        avalid_r, avalid_nxt;
   sel_t        picked;
   logic        setup, hit;
   logic [31:0] lane_mask;

   assign setup = psel && !penable;
   assign hit   = (paddr[11:2] == SEL_REG_OFFSET[11:2]);

   // Byte strobes expanded into a bit mask
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         lane_mask[i*8 +: 8] = {8{pstrb[i]}};
      end
   end

   // Answer is registered in the setup cycle so the access phase ends in one cycle
   always_comb begin
      sel_word_nxt = sel_word_r;
      prdata_nxt   = 32'h0000_0000;
      pready_nxt   = 1'b0;
      pslverr_nxt  = 1'b0;
      if (setup) begin
         pready_nxt  = 1'b1;
         pslverr_nxt = !hit;
         if (hit && !pwrite) begin
            prdata_nxt = sel_word_r & SEL_WRITE_MASK;
         end
      end
      if (psel && penable && pready_r && pwrite && hit) begin
         // Reserved bits stay zero whatever software writes
         sel_word_nxt = (sel_word_r & ~(lane_mask & SEL_WRITE_MASK))
                      | (pwdata & lane_mask & SEL_WRITE_MASK);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_word_r <= SEL_REG_RESET;
         prdata_r   <= 32'h0000_0000;
         pready_r   <= 1'b0;
         pslverr_r  <= 1'b0;
      end else begin
         sel_word_r <= sel_word_nxt;
         prdata_r   <= prdata_nxt;
         pready_r   <= pready_nxt;
         pslverr_r  <= pslverr_nxt;
      end
   end

   step_field_pick u_pick (
      .word (sel_word_r),
      .step (seq_step),
      .sel  (picked)
   );

   // Select follows the step one cycle later; held while idle so the mux does not glitch
   always_comb begin
      amux_nxt   = amux_r;
      avalid_nxt = seq_running;
      if (seq_running) begin
         amux_nxt = picked;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         amux_r   <= '0;
         avalid_r <= 1'b0;
      end else begin
         amux_r   <= amux_nxt;
         avalid_r <= avalid_nxt;
      end
   end

   assign prdata           = prdata_r;
   assign pready           = pready_r;
   assign pslverr          = pslverr_r;
   assign analog_input_sel = amux_r;
   assign analog_sel_valid = avalid_r;

   property p_step5_sel;
      @(posedge pclk) disable iff (!presetn)
      (seq_running && seq_step == 3'd4) |=> (analog_input_sel == $past(sel_word_r[17:16]));
   endproperty
   a_step5_sel: assert property (p_step5_sel) else $error("step five select wrong");

   property p_step4_sel;
      @(posedge pclk) disable iff (!presetn)
      (seq_running && seq_step == 3'd3) |=> (analog_input_sel == $past(sel_word_r[13:12]));
   endproperty
   a_step4_sel: assert property (p_step4_sel) else $error("step four select wrong");

   property p_step3_sel;
      @(posedge pclk) disable iff (!presetn)
      (seq_running && seq_step == 3'd2) |=> (analog_input_sel == $past(sel_word_r[9:8]));
   endproperty
   a_step3_sel: assert property (p_step3_sel) else $error("step three select wrong");

   property p_step2_sel;
      @(posedge pclk) disable iff (!presetn)
      (seq_running && seq_step == 3'd1) |=> (analog_input_sel == $past(sel_word_r[5:4]));
   endproperty
   a_step2_sel: assert property (p_step2_sel) else $error("step two select wrong");

   property p_step1_sel;
      @(posedge pclk) disable iff (!presetn)
      (seq_running && seq_step == 3'd0) |=> (analog_input_sel == $past(sel_word_r[1:0]));
   endproperty
   a_step1_sel: assert property (p_step1_sel) else $error("step one select wrong");

   property p_gaps_zero;
      @(posedge pclk) disable iff (!presetn)
      (sel_word_r & ~SEL_WRITE_MASK) == 32'h0000_0000;
   endproperty
   a_gaps_zero: assert property (p_gaps_zero) else $error("reserved bits not zero");

   property p_read_gaps;
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready) |-> ((prdata & ~SEL_WRITE_MASK) == 32'h0000_0000);
   endproperty
   a_read_gaps: assert property (p_read_gaps) else $error("read shows reserved bits");

   property p_upper_write;
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && pwrite && hit && pstrb[3])
      |=> (sel_word_r[29:28] == $past(pwdata[29:28]));
   endproperty
   a_upper_write: assert property (p_upper_write) else $error("step eight field not written");

   property p_one_wait;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("no ready after setup");

   property p_step6_sel;
      @(posedge pclk) disable iff (!presetn)
      (seq_running && seq_step == 3'd5) |=> (analog_input_sel == $past(sel_word_r[STEP6_LSB +: SEL_W]));
   endproperty
   a_step6_sel: assert property (p_step6_sel) else $error("step six select wrong");

   property p_step7_sel;
      @(posedge pclk) disable iff (!presetn)
      (seq_running && seq_step == 3'd6) |=> (analog_input_sel == $past(sel_word_r[STEP7_LSB +: SEL_W]));
   endproperty
   a_step7_sel: assert property (p_step7_sel) else $error("step seven select wrong");

   property p_step8_sel;
      @(posedge pclk) disable iff (!presetn)
      (seq_running && seq_step == 3'd7) |=> (analog_input_sel == $past(sel_word_r[STEP8_LSB +: SEL_W]));
   endproperty
   a_step8_sel: assert property (p_step8_sel) else $error("step eight select wrong");

   property p_low_write;
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && pwrite && hit && pstrb[0])
      |=> (sel_word_r[STEP1_LSB +: SEL_W] == $past(pwdata[STEP1_LSB +: SEL_W]));
   endproperty
   a_low_write: assert property (p_low_write) else $error("step one field not written");

   property p_mid_write;
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && pwrite && hit && pstrb[2])
      |=> (sel_word_r[STEP5_LSB +: SEL_W] == $past(pwdata[STEP5_LSB +: SEL_W]));
   endproperty
   a_mid_write: assert property (p_mid_write) else $error("step five field not written");

   // Partial writes must not disturb the top lane (bits 31:24) when its strobe is low
   property p_lane_keep;
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && pwrite && hit && !pstrb[3])
      |=> (sel_word_r[31:24] == $past(sel_word_r[31:24]));
   endproperty
   a_lane_keep: assert property (p_lane_keep) else $error("unstrobed lane changed");

   property p_unmapped_keep;
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && !hit) |=> $stable(sel_word_r);
   endproperty
   a_unmapped_keep: assert property (p_unmapped_keep) else $error("unmapped access changed register");

   property p_unmapped_err;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !hit) |=> pslverr;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err) else $error("no error for unmapped address");

   property p_read_data;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && hit && !pwrite) |=> (prdata == ($past(sel_word_r) & SEL_WRITE_MASK));
   endproperty
   a_read_data: assert property (p_read_data) else $error("read data wrong");

   property p_valid_follow;
      @(posedge pclk) disable iff (!presetn)
      analog_sel_valid == $past(seq_running);
   endproperty
   a_valid_follow: assert property (p_valid_follow) else $error("select valid does not follow running");

   c_write: cover property (@(posedge pclk) disable iff (!presetn) psel && penable && pready && pwrite && hit);
   c_read: cover property (@(posedge pclk) disable iff (!presetn) psel && penable && pready && !pwrite && hit);
   c_bad: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
   c_step8: cover property (@(posedge pclk) disable iff (!presetn) seq_running && seq_step == 3'd7);
   c_done: cover property (@(posedge pclk) disable iff (!presetn) $fell(analog_sel_valid));
endmodule

// file: bench/seq_mux_model.sv
// Sequencer and input mux model: walks eight steps, logs the select per step.
// Assumes the design's select output and valid flag on the same pclk.
`timescale 1ns/100ps
module seq_mux_model
   import step_select_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        start,
   input  wire sel_t        analog_input_sel,
   input  wire logic        analog_sel_valid,
   output logic             seq_running,
   output logic [2:0]       seq_step,
   output logic [15:0]      seen
);
   logic [1:0] hold_r;
   // Three edges per step so either select latency is settled at capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_running <= 1'b0;
         seq_step <= 3'h0;
         hold_r <= 2'h0;
         seen <= 16'h0;
      end else if (start && !seq_running) begin
         seq_running <= 1'b1;
         seq_step <= 3'h0;
         hold_r <= 2'h0;
      end else if (seq_running) begin
         hold_r <= hold_r + 2'h1;
         if (hold_r == 2'h2) begin
            seen[2*seq_step +: 2] <= {2{analog_sel_valid}} & analog_input_sel;
            hold_r <= 2'h0;
            seq_step <= seq_step + 3'h1;
            if (seq_step == 3'h7) begin
               seq_running <= 1'b0;
            end
         end
      end
   end
endmodule

// file: bench/testbench.sv
// Self-checking bench: APB master, sequencer model, per-scenario tasks.
// Assumes the design package and the sequencer model compile first.
`timescale 1ns/100ps
module testbench
   import step_select_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hf;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        seq_running;
   logic [2:0]  seq_step;
   sel_t        analog_input_sel;
   logic        analog_sel_valid;
   logic        start = 1'b0;
   logic [15:0] seen;
   logic [15:0] x;
   logic [31:0] q;
   logic        e;
   int          miscompares = 0;
   int          check_count = 0;
   always #25 pclk = ~pclk;
   seq_input_select seq_input_select_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .seq_running(seq_running), .seq_step(seq_step),
      .analog_input_sel(analog_input_sel), .analog_sel_valid(analog_sel_valid));
   seq_mux_model seq_mux_model_inst (.pclk(pclk), .presetn(presetn), .start(start), .seen(seen),
      .analog_input_sel(analog_input_sel), .analog_sel_valid(analog_sel_valid),
      .seq_running(seq_running), .seq_step(seq_step));
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge pclk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      pstrb <= s;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // Pre-edge values: flops update only after this edge
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk("ready", 32'h1, {31'h0, pready});
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] xv, input logic [31:0] g);
      check_count++;
      if (g !== xv) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, xv, g);
      end
   endtask
   task automatic rd_chk(input logic [31:0] xv);
      apb(SEL_REG_OFFSET, 1'b0, 32'h0, 4'hf);
      chk("select word", xv, q);
   endtask
   task automatic test_reset();
      rd_chk(32'h0);
      chk("error flag", 32'h0, {31'h0, e});
      $display("test_reset done");
   endtask
   task automatic test_access();
      apb(SEL_REG_OFFSET, 1'b1, 32'hffff_ffff, 4'hf);
      rd_chk(32'h3333_3333);
      apb(SEL_REG_OFFSET, 1'b1, 32'hcccc_cccc, 4'hf);
      rd_chk(32'h0);
      apb(SEL_REG_OFFSET, 1'b1, 32'h3333_3333, 4'hf);
      apb(SEL_REG_OFFSET, 1'b0, 32'h0, 4'hf);
      apb(SEL_REG_OFFSET, 1'b1, (q & ~32'h0000_0300) | 32'h0000_0100, 4'hf);
      rd_chk(32'h3333_3133);
      apb(SEL_REG_OFFSET, 1'b1, 32'h0, 4'h1);
      rd_chk(32'h3333_3100);
      $display("test_access done");
   endtask
   task automatic test_unmapped();
      apb(12'h004, 1'b1, 32'hffff_ffff, 4'hf);
      chk("error flag", 32'h1, {31'h0, e});
      apb(12'h004, 1'b0, 32'h0, 4'hf);
      chk("unmapped data", 32'h0, q);
      rd_chk(32'h3333_3100);
      $display("test_unmapped done");
   endtask
   task automatic test_sequence();
      int n;
      apb(SEL_REG_OFFSET, 1'b1, 32'h2132_0321, 4'hf);
      for (n = 0; n < 8; n++) begin
         x[2*n +: 2] = 2'(32'h2132_0321 >> (4*n));
      end
      @(posedge pclk);
      start <= 1'b1;
      @(posedge pclk);
      start <= 1'b0;
      @(posedge pclk);
      for (n = 0; n < 60 && seq_running !== 1'b0; n++) begin
         @(posedge pclk);
      end
      chk("sequence end", 32'h0, {31'h0, seq_running});
      @(negedge pclk);
      chk("select valid", 32'h0, {31'h0, analog_sel_valid});
      chk("step selects", {16'h0, x}, {16'h0, seen});
      chk("idle select", 32'h2, {30'h0, analog_input_sel});
      $display("test_sequence done");
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      miscompares++;
      give_verdict();
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      test_reset();
      test_access();
      test_unmapped();
      test_sequence();
      give_verdict();
   end
endmodule
